// file: inc/rpom_pkg.sv
package rpom_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NPINS = 8;
  localparam int NINSEL = 4;
  localparam int SEL_W = 6;
  localparam int INSEL_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ****************************************
  // output selection codes
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_DEFAULT = 6'h00;
  localparam logic [SEL_W-1:0] SEL_SER1_TX = 6'h01;
  localparam logic [SEL_W-1:0] SEL_SER2_TX = 6'h03;
  localparam logic [SEL_W-1:0] SEL_SPI2_DO = 6'h08;
  localparam logic [SEL_W-1:0] SEL_SPI2_CK = 6'h09;
  localparam logic [SEL_W-1:0] SEL_SPI2_SS = 6'h0A;
  localparam logic [SEL_W-1:0] SEL_CAN_TX = 6'h0E;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT1 = 6'h10;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT2 = 6'h11;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT3 = 6'h12;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT4 = 6'h13;
  localparam logic [SEL_W-1:0] SEL_COMPR1 = 6'h18;
  localparam logic [SEL_W-1:0] SEL_COMPR2 = 6'h19;
  localparam logic [SEL_W-1:0] SEL_COMPR3 = 6'h1A;
  localparam logic [SEL_W-1:0] SEL_PWM_SYNC = 6'h2D;
  localparam logic [SEL_W-1:0] SEL_REF_CLK = 6'h31;
  localparam logic [SEL_W-1:0] SEL_COMPR4 = 6'h32;
  localparam logic [SEL_W-1:0] SEL_COMPR5 = 6'h33;
  localparam logic [SEL_W-1:0] SEL_SENT_TX_ONE = 6'h39;
  localparam logic [SEL_W-1:0] SEL_SENT_TX_TWO = 6'h3A;

  // input select: value 0 ground, 1 comparator one, 2+n pin n
  localparam logic [INSEL_W-1:0] INSEL_GND = 8'h00;
  localparam logic [INSEL_W-1:0] INSEL_COMPARATOR_ONE_INPUT_SOURCE = 8'h01;
  localparam logic [INSEL_W-1:0] INSEL_PIN0 = 8'h02;

  // ****************************************
  // register map (word index = address)
  // ****************************************
  localparam logic [ADDR_W-1:0] A_OUTSEL0 = 8'h00; // one per pin, 0x00..0x07
  localparam logic [ADDR_W-1:0] A_INSEL0 = 8'h10;  // one per input, 0x10..0x13
  localparam logic [ADDR_W-1:0] A_DIR = 8'h20;
  localparam logic [ADDR_W-1:0] A_LATCH = 8'h21;
  localparam logic [ADDR_W-1:0] A_ANSEL = 8'h22;
  localparam logic [ADDR_W-1:0] A_PULLUP = 8'h23;
  localparam logic [ADDR_W-1:0] A_PULLDN = 8'h24;
  localparam logic [ADDR_W-1:0] A_DEDEN = 8'h25;
  localparam logic [ADDR_W-1:0] A_LEVEL = 8'h26;

  localparam logic [NPINS-1:0] RST_DIR = 8'hFF;
  localparam logic [NPINS-1:0] RST_ANSEL = 8'hFF;
  localparam logic [NPINS-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ser1_tx;
    logic ser2_tx;
    logic spi2_do;
    logic spi2_ck;
    logic spi2_ss;
    logic can_tx;
    logic [3:0] cmp_out;
    logic [4:0] compr;
    logic pwm_sync;
    logic ref_clk;
    logic sent_tx_one;
    logic sent_tx_two;
  } rpom_periph_t;

  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pu;
    logic [NPINS-1:0] pd;
  } rpom_pad_t;
endpackage

// file: logic/rpom_top.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module rpom_top import rpom_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // peripherals
  input wire rpom_periph_t periph,
  input wire logic [NPINS-1:0] ded_out_en,
  input wire logic [NPINS-1:0] ded_out_val,
  output logic [NINSEL-1:0] periph_in,
  // pins
  input wire logic [NPINS-1:0] pin_in,
  output rpom_pad_t pad,
  // supply monitor
  input wire logic core_overvoltage_detect
);

  // ****************************************
  // register state
  // ****************************************
  logic [SEL_W-1:0] outsel_q [NPINS];
  logic [SEL_W-1:0] outsel_d [NPINS];
  logic [INSEL_W-1:0] insel_q [NINSEL];
  logic [INSEL_W-1:0] insel_d [NINSEL];
  logic [NPINS-1:0] dir_q, lat_q, ansel_q, pu_q, pd_q, deden_q;
  logic [DATA_W-1:0] rdata_d;
  logic [NPINS-1:0] level_in;

  // digital input buffer is gated only by the analog bits, never direction
  assign level_in = pin_in & ~ansel_q;

  always_comb begin
    outsel_d = outsel_q;
    insel_d = insel_q;
    rdata_d = RD_ZERO;
    // independent fields, no lockout between them
    if (reg_wr) begin
      for (int i = 0; i < NPINS; i++) begin
        if (reg_addr == A_OUTSEL0 + ADDR_W'(i)) begin
          outsel_d[i] = reg_wdata[SEL_W-1:0];
        end
      end
      for (int j = 0; j < NINSEL; j++) begin
        if (reg_addr == A_INSEL0 + ADDR_W'(j)) begin
          insel_d[j] = reg_wdata[INSEL_W-1:0];
        end
      end
    end
    if (reg_rd) begin
      for (int i = 0; i < NPINS; i++) begin
        if (reg_addr == A_OUTSEL0 + ADDR_W'(i)) begin
          rdata_d = {{(DATA_W-SEL_W){1'b0}}, outsel_q[i]};
        end
      end
      for (int j = 0; j < NINSEL; j++) begin
        if (reg_addr == A_INSEL0 + ADDR_W'(j)) begin
          rdata_d = {{(DATA_W-INSEL_W){1'b0}}, insel_q[j]};
        end
      end
      unique case (reg_addr)
        A_DIR: rdata_d = {{(DATA_W-NPINS){1'b0}}, dir_q};
        // latch reads also return zero on analog pins
        A_LATCH: rdata_d = {{(DATA_W-NPINS){1'b0}}, lat_q & ~ansel_q};
        A_ANSEL: rdata_d = {{(DATA_W-NPINS){1'b0}}, ansel_q};
        A_PULLUP: rdata_d = {{(DATA_W-NPINS){1'b0}}, pu_q};
        A_PULLDN: rdata_d = {{(DATA_W-NPINS){1'b0}}, pd_q};
        A_DEDEN: rdata_d = {{(DATA_W-NPINS){1'b0}}, deden_q};
        A_LEVEL: rdata_d = {{(DATA_W-NPINS){1'b0}}, level_in};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NPINS; i++) begin
        outsel_q[i] <= SEL_DEFAULT;
      end
      for (int j = 0; j < NINSEL; j++) begin
        insel_q[j] <= INSEL_GND;
      end
      reg_rdata <= RD_ZERO;
    end else begin
      outsel_q <= outsel_d;
      insel_q <= insel_d;
      reg_rdata <= rdata_d;
    end
  end

  // ****************************************
  // configuration bits
  // ****************************************
  rpom_cfg_reg #(.ADDR(A_DIR), .RST(RST_DIR)) u_rpom_cfg_reg_dir (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(dir_q)
  );
  rpom_cfg_reg #(.ADDR(A_LATCH), .RST(RST_ZERO)) u_rpom_cfg_reg_lat (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(lat_q)
  );
  rpom_cfg_reg #(.ADDR(A_ANSEL), .RST(RST_ANSEL)) u_rpom_cfg_reg_ansel (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(ansel_q)
  );
  rpom_cfg_reg #(.ADDR(A_PULLUP), .RST(RST_ZERO)) u_rpom_cfg_reg_pu (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(pu_q)
  );
  rpom_cfg_reg #(.ADDR(A_PULLDN), .RST(RST_ZERO)) u_rpom_cfg_reg_pd (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(pd_q)
  );
  rpom_cfg_reg #(.ADDR(A_DEDEN), .RST(RST_ZERO)) u_rpom_cfg_reg_deden (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .bits_q(deden_q)
  );

  // ****************************************
  // output arbitration
  // ****************************************
  rpom_pad_t pad_d;
  logic [NINSEL-1:0] pin_in_d;
  logic [NPINS-1:0] arb_val;
  logic [NPINS-1:0] arb_en;

  // one arbiter per pin, all fed the same peripheral bus
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    rpom_pin_arb u_rpom_pin_arb (
      .sel(outsel_q[i]),
      .dir_bit(dir_q[i]),
      .lat_bit(lat_q[i]),
      .periph(periph),
      .ded_en(ded_out_en[i]),
      .ded_val(ded_out_val[i]),
      .drv_val(arb_val[i]),
      .drv_en(arb_en[i])
    );
  end

  always_comb begin
    pad_d.out = arb_val;
    pad_d.oe = arb_en;
    pad_d.pu = pu_q;
    pad_d.pd = pd_q;
    // overvoltage wins over every function, pulls included
    if (core_overvoltage_detect) begin
      pad_d = '0;
    end
  end

  // ****************************************
  // input selection
  // ****************************************
  for (genvar j = 0; j < NINSEL; j++) begin : g_in
    rpom_in_sel u_rpom_in_sel (
      .sel(insel_q[j]),
      .cmp_one(periph.compr[0]),
      .level(level_in),
      .ovd(core_overvoltage_detect),
      .sel_val(pin_in_d[j])
    );
  end

  // outputs registered: one cycle latency from peripheral to pad
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad <= '0;
      periph_in <= '0;
    end else begin
      pad <= pad_d;
      periph_in <= pin_in_d;
    end
  end
endmodule

// ****************************************
// per-pin output arbitration
// ****************************************
module rpom_pin_arb import rpom_pkg::*; (
  // selection state
  input wire logic [SEL_W-1:0] sel,
  input wire logic dir_bit,
  input wire logic lat_bit,
  // drivers
  input wire rpom_periph_t periph,
  input wire logic ded_en,
  input wire logic ded_val,
  // pad drive
  output logic drv_val,
  output logic drv_en
);

  logic remap_val;
  logic remap_act;

  always_comb begin
    remap_val = 1'b0;
    remap_act = 1'b1;
    unique case (sel)
      SEL_SER1_TX: remap_val = periph.ser1_tx;
      SEL_SER2_TX: remap_val = periph.ser2_tx;
      SEL_SPI2_DO: remap_val = periph.spi2_do;
      SEL_SPI2_CK: remap_val = periph.spi2_ck;
      SEL_SPI2_SS: remap_val = periph.spi2_ss;
      SEL_CAN_TX: remap_val = periph.can_tx;
      SEL_CMP_OUT1: remap_val = periph.cmp_out[0];
      SEL_CMP_OUT2: remap_val = periph.cmp_out[1];
      SEL_CMP_OUT3: remap_val = periph.cmp_out[2];
      SEL_CMP_OUT4: remap_val = periph.cmp_out[3];
      SEL_COMPR1: remap_val = periph.compr[0];
      SEL_COMPR2: remap_val = periph.compr[1];
      SEL_COMPR3: remap_val = periph.compr[2];
      SEL_COMPR4: remap_val = periph.compr[3];
      SEL_COMPR5: remap_val = periph.compr[4];
      SEL_PWM_SYNC: remap_val = periph.pwm_sync;
      SEL_REF_CLK: remap_val = periph.ref_clk;
      SEL_SENT_TX_ONE: remap_val = periph.sent_tx_one;
      SEL_SENT_TX_TWO: remap_val = periph.sent_tx_two;
      default: begin
        // code zero and unlisted codes leave the default port function
        remap_val = 1'b0;
        remap_act = 1'b0;
      end
    endcase
  end

  // one driver per pin: dedicated, then remappable, then port latch
  always_comb begin
    if (ded_en) begin
      drv_val = ded_val;
      drv_en = 1'b1;
    end else if (remap_act) begin
      drv_val = remap_val;
      drv_en = 1'b1;
    end else begin
      drv_val = lat_bit;
      // analog select does not block the driver; contention is software's care
      drv_en = ~dir_bit;
    end
  end
endmodule

// ****************************************
// per-input pin selection
// ****************************************
module rpom_in_sel import rpom_pkg::*; (
  // selection state
  input wire logic [INSEL_W-1:0] sel,
  // sources
  input wire logic cmp_one,
  input wire logic [NPINS-1:0] level,
  input wire logic ovd,
  // selected input
  output logic sel_val
);
  always_comb begin
    sel_val = 1'b0;
    // any number of selectors may name the same pin
    if (sel == INSEL_COMPARATOR_ONE_INPUT_SOURCE) begin
      sel_val = cmp_one;
    end
    for (int i = 0; i < NPINS; i++) begin
      if (sel == INSEL_PIN0 + INSEL_W'(i)) begin
        sel_val = level[i];
      end
    end
    // pads and selected inputs are dead while the core supply is too high; level register reads still see the pins
    if (ovd) begin
      sel_val = 1'b0;
    end
  end
endmodule

// ****************************************
// eight-bit configuration register
// ****************************************
module rpom_cfg_reg import rpom_pkg::*; #(
  parameter logic [ADDR_W-1:0] ADDR = A_DIR,
  parameter logic [NPINS-1:0] RST = RST_ZERO
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // stored bits
  output logic [NPINS-1:0] bits_q
);
  logic [NPINS-1:0] bits_d;

  always_comb begin
    bits_d = bits_q;
    if (reg_wr && reg_addr == ADDR) begin
      bits_d = reg_wdata[NPINS-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bits_q <= RST;
    end else begin
      bits_q <= bits_d;
    end
  end
endmodule

// file: bench/rpom_top_asserts.sv
`timescale 1ns/1ps
module rpom_top_asserts import rpom_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // peripheral and pin side
  input wire rpom_periph_t periph,
  input wire logic [NPINS-1:0] ded_out_en,
  input wire logic [NPINS-1:0] ded_out_val,
  input wire logic [NINSEL-1:0] periph_in,
  input wire logic [NPINS-1:0] pin_in,
  input wire rpom_pad_t pad,
  input wire logic core_overvoltage_detect
);
  // ****************************************
  // shadow registers
  // ****************************************
  logic [NPINS-1:0] pu_q, pd_q, an_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_q <= RST_ZERO;
      pd_q <= RST_ZERO;
      an_q <= RST_ANSEL;
    end else if (reg_wr) begin
      if (reg_addr == A_PULLUP) pu_q <= reg_wdata[NPINS-1:0];
      if (reg_addr == A_PULLDN) pd_q <= reg_wdata[NPINS-1:0];
      if (reg_addr == A_ANSEL) an_q <= reg_wdata[NPINS-1:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ovd_tristate_a: assert property ($past(core_overvoltage_detect) |-> pad == '0 && periph_in == '0)
    else $error("pads not released under overvoltage");
  ded_oe_a: assert property ($past(arst_n) && !$past(core_overvoltage_detect) |->
    (pad.oe & $past(ded_out_en)) == $past(ded_out_en)) else $error("dedicated pin not driven");
  ded_value_a: assert property ($past(arst_n) && !$past(core_overvoltage_detect) |->
    ((pad.out ^ $past(ded_out_val)) & $past(ded_out_en)) == '0) else $error("dedicated value lost");
  reset_idle_a: assert property ($rose(arst_n) |-> pad.oe == '0 ##1
    pad.oe == ($past(ded_out_en) & {NPINS{!$past(core_overvoltage_detect)}})) else $error("pin driven after reset");
  pullup_follow_a: assert property ($past(arst_n) && !$past(core_overvoltage_detect) |-> pad.pu == $past(pu_q))
    else $error("pull-up mismatch");
  pulldn_follow_a: assert property ($past(arst_n) && !$past(core_overvoltage_detect) |-> pad.pd == $past(pd_q))
    else $error("pull-down mismatch");
  sel_width_a: assert property ($past(reg_rd && reg_addr < 8'h08) |-> reg_rdata[DATA_W-1:SEL_W] == '0)
    else $error("selector wider than six bits");
  level_read_a: assert property ($past(reg_rd && reg_addr == A_LEVEL) |->
    reg_rdata == {{(DATA_W-NPINS){1'h0}}, $past(pin_in & ~an_q)}) else $error("analog pin reads nonzero");
endmodule
bind rpom_top rpom_top_asserts u_rpom_top_asserts (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph(periph),
  .ded_out_en(ded_out_en), .ded_out_val(ded_out_val), .periph_in(periph_in), .pin_in(pin_in), .pad(pad),
  .core_overvoltage_detect(core_overvoltage_detect));

// file: bench/rpom_pin_model.sv
`timescale 1ns/1ps
module rpom_pin_model import rpom_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pad side
  input wire rpom_pad_t pad,
  output logic [NPINS-1:0] pin_level
);
  // ****************************************
  // pin resolution
  // ****************************************
  // a floating pin wanders every cycle, so nobody may rely on it
  logic [NPINS-1:0] float_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) float_q <= 8'h5A;
    else float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pad.oe[i]) pin_level[i] = pad.out[i];
      else if (pad.pu[i]) pin_level[i] = 1'h1;
      else if (pad.pd[i]) pin_level[i] = 1'h0;
      else pin_level[i] = float_q[i];
    end
  end
endmodule

// file: bench/rpom_top_tb_top.sv
`timescale 1ns/1ps
module rpom_top_tb_top import rpom_pkg::*;;
  // ****************************************
  // stimulus and scoreboard
  // ****************************************
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, ovd = 0, rd_due = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [NPINS-1:0] den = '0, dval = '0, pin_in, dir = 8'hF0, lat = 8'hA5, pu = 8'hF0, pd = 8'h0F, an = 8'h01;
  logic [SEL_W-1:0] sel [NPINS] = '{default: '0};
  logic [7:0] ins [NINSEL] = '{8'h01, 8'h02, 8'h04, 8'h04};
  rpom_periph_t periph = '0;
  rpom_pad_t pad;
  logic [NINSEL-1:0] periph_in;
  logic [35:0] e;
  logic [DATA_W-1:0] rd_q [$];
  logic [35:0] pad_q [$];
  int num_errors = 0, checks = 0, cyc = 0;
  logic [5:0] codes [19] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0A, 6'h0E, 6'h10, 6'h11, 6'h12, 6'h13, 6'h18,
    6'h19, 6'h1A, 6'h2D, 6'h31, 6'h32, 6'h33, 6'h39, 6'h3A};
  int bits [19] = '{18, 17, 16, 15, 14, 13, 9, 10, 11, 12, 4, 5, 6, 3, 2, 7, 8, 1, 0};
  always #2 clk = ~clk;
  rpom_top u_rpom_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph(periph), .ded_out_en(den), .ded_out_val(dval),
    .periph_in(periph_in), .pin_in(pin_in), .pad(pad), .core_overvoltage_detect(ovd));
  rpom_pin_model u_rpom_pin_model (.clk(clk), .arst_n(arst_n), .pad(pad), .pin_level(pin_in));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_word(logic [15:0] x, logic [15:0] s);
    checks++;
    if (x !== s) begin
      num_errors++;
      $display("FAIL rdata exp %h got %h", x, s);
    end
  endtask
  task automatic cmp_pins(logic [35:0] x, logic [35:0] s);
    checks++;
    if (x !== s) begin
      num_errors++;
      $display("FAIL pins exp %h got %h", x, s);
    end
  endtask
  always @(posedge clk) begin
    rd_due <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  always @(negedge clk) begin
    if (rd_due) cmp_word(rd_q.pop_front(), reg_rdata);
    if (pad_q.size() > 0) begin
      e = pad_q.pop_front();
      cmp_pins(e, {pad.oe, pad.out & e[35:28], pad.pu, pad.pd, periph_in});
    end
  end
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] x);
    reg_addr <= a;
    reg_rd <= 1'h1;
    reg_wr <= 1'h0;
    rd_q.push_back(x);
    @(posedge clk);
  endtask
  task automatic idle(int n);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wsel(int p, logic [5:0] c);
    sel[p] = c;
    wr(A_OUTSEL0 + ADDR_W'(p), DATA_W'(c));
  endtask
  function automatic logic [35:0] exp_pins();
    logic [7:0] oe, out, lvl;
    logic [3:0] pin;
    for (int i = 0; i < 8; i++) begin
      oe[i] = !dir[i];
      out[i] = lat[i];
      for (int k = 0; k < 19; k++) begin
        if (sel[i] == codes[k]) {oe[i], out[i]} = {1'h1, periph[bits[k]]};
      end
      if (den[i]) {oe[i], out[i]} = {1'h1, dval[i]};
    end
    lvl = ((oe & out) | (~oe & pu)) & ~an;
    for (int j = 0; j < 4; j++) pin[j] = ins[j] == 8'h00 ? 1'h0 : ins[j] == 8'h01 ? periph.compr[0] : lvl[ins[j] - 8'h02];
    return ovd ? 36'h0 : {oe, out & oe, pu, pd, pin};
  endfunction
  task automatic chk();
    idle(3);
    pad_q.push_back(exp_pins());
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(91600));
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    rd(8'h03, 16'h0000);
    rd(A_ANSEL, 16'h00FF);
    rd(A_LEVEL, 16'h0000);
    rd(8'h30, 16'h0000);
    wr(A_DIR, {8'h00, dir});
    wr(A_LATCH, {8'h00, lat});
    wr(A_PULLUP, {8'h00, pu});
    wr(A_PULLDN, {8'h00, pd});
    wr(A_ANSEL, {8'h00, an});
    rd(A_LATCH, 16'h00A4);
    for (int j = 0; j < 4; j++) wr(A_INSEL0 + ADDR_W'(j), {8'h00, ins[j]});
    periph <= rpom_periph_t'(19'($urandom));
    chk();
    rd(A_LEVEL, 16'h00F4);
    for (int k = 0; k < 38; k++) begin
      periph <= rpom_periph_t'(19'($urandom));
      den <= 8'($urandom) & 8'h81;
      dval <= 8'($urandom);
      wsel(4 + k % 4, codes[k % 19]);
      wsel(k % 4, codes[k % 19]);
      chk();
    end
    wsel(1, 6'h00);
    wsel(5, 6'h3F);
    wsel(6, 6'h20);
    chk();
    wsel(7, 6'h3F);
    rd(8'h07, 16'h003F);
    ovd <= 1'h1;
    chk();
    ovd <= 1'h0;
    chk();
    arst_n <= 1'h0;
    @(posedge clk);
    arst_n <= 1'h1;
    rd(8'h07, 16'h0000);
    rd(A_ANSEL, 16'h00FF);
    idle(2);
    tally_and_finish();
  end
endmodule
